// *** logic/alu_pkg.sv ***
package alu_pkg;

  localparam int ALU_WORD_W = 16;
  localparam int ALU_BYTE_W = 8;
  localparam int ALU_WORD_MSB = 15;
  localparam int ALU_BYTE_MSB = 7;

  // Status register layout
  localparam int ALU_SR_C = 0;
  localparam int ALU_SR_Z = 1;
  localparam int ALU_SR_N = 2;
  localparam int ALU_SR_GIE = 3;
  localparam int ALU_SR_CPU_HALT = 4;
  localparam int ALU_SR_OSC_HALT = 5;
  localparam int ALU_SR_V = 8;

  localparam logic [15:0] ALU_ZERO_WORD = 16'h0000;
  localparam logic [15:0] ALU_LOW_MASK = 16'h00ff;
  localparam logic [15:0] ALU_SR_RESET = 16'h0000;
  localparam logic [15:0] ALU_PC_RESET = 16'h0000;

  // Byte/word select bit value for byte execution
  localparam logic ALU_BW_BYTE = 1'b1;

  typedef enum logic [2:0] {
    ALU_OP_ADD = 3'h0,
    ALU_OP_SUM_WITH_CARRY = 3'h1,
    ALU_OP_ADD_CARRY_ONLY = 3'h2,
    ALU_OP_AND = 3'h3,
    ALU_OP_CLEAR_MASKED_BITS = 3'h4,
    ALU_OP_SET_MASKED_BITS = 3'h5,
    ALU_OP_TEST = 3'h6,
    ALU_OP_JUMP_TO_TARGET = 3'h7
  } alu_op_type;

  typedef enum logic [1:0] {
    ALU_ST_IDLE = 2'b00,
    ALU_ST_DONE = 2'b01
  } alu_state_type;

  typedef struct packed {
    alu_op_type op;
    logic byte_sel;
    logic dst_is_sr;
    logic [15:0] src;
    logic [15:0] dst;
  } alu_req_type;

  typedef struct packed {
    logic [15:0] value;
    logic v;
    logic n;
    logic z;
    logic c;
  } alu_res_type;

endpackage

// *** logic/alu_adder.sv ***
`timescale 1ns/1ns
module alu_adder
  import alu_pkg::*;
(
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic carry_in,
  input wire logic byte_sel,
  output alu_res_type res
);

  logic [16:0] wide;
  logic [8:0] narrow;
  logic [15:0] sum;
  logic a_msb;
  logic b_msb;
  logic s_msb;

  always_comb begin
    wide = {1'b0, a} + {1'b0, b} + {16'h0000, carry_in};
    narrow = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, carry_in};
    // Byte mode: bit 7 is the sign bit, upper byte cleared
    if (byte_sel) begin
      sum = {8'h00, narrow[7:0]};
      res.c = narrow[8];
      a_msb = a[ALU_BYTE_MSB];
      b_msb = b[ALU_BYTE_MSB];
      s_msb = narrow[ALU_BYTE_MSB];
    end else begin
      sum = wide[15:0];
      res.c = wide[16];
      a_msb = a[ALU_WORD_MSB];
      b_msb = b[ALU_WORD_MSB];
      s_msb = wide[ALU_WORD_MSB];
    end
    res.value = sum;
    res.n = s_msb;
    res.z = (sum == ALU_ZERO_WORD);
    res.v = (a_msb == b_msb) && (s_msb != a_msb);
  end

endmodule

// *** logic/alu_logic_unit.sv ***
`timescale 1ns/1ns
module alu_logic_unit
  import alu_pkg::*;
(
  input wire alu_op_type op,
  input wire logic [15:0] src,
  input wire logic [15:0] dst,
  input wire logic byte_sel,
  output alu_res_type res
);

  logic [15:0] raw;
  logic [15:0] val;

  always_comb begin
    case (op)
      ALU_OP_CLEAR_MASKED_BITS: raw = ~src & dst;
      ALU_OP_SET_MASKED_BITS: raw = src | dst;
      default: raw = src & dst;
    endcase
    val = byte_sel ? (raw & ALU_LOW_MASK) : raw;
    res.value = val;
    res.z = (val == ALU_ZERO_WORD);
    res.n = byte_sel ? val[ALU_BYTE_MSB] : val[ALU_WORD_MSB];
    res.c = ~res.z;
    res.v = 1'b0;
  end

endmodule

// *** logic/alu_core.sv ***
`timescale 1ns/1ns
module alu_core
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire alu_req_type req,
  output logic dst_we,
  output logic [15:0] dst_data,
  output logic pc_we,
  output logic [15:0] pc,
  output logic [15:0] status,
  output logic done
);

  typedef struct packed {
    alu_state_type st;
    logic dst_we;
    logic [15:0] dst_data;
    logic pc_we;
    logic [15:0] pc;
    logic [15:0] status;
  } alu_regs_type;

  alu_regs_type cur;
  alu_regs_type next_cur;
  alu_res_type add_res;
  alu_res_type log_res;
  logic [15:0] add_src;
  logic add_cin;
  logic byte_mode;

  assign byte_mode = (req.byte_sel == ALU_BW_BYTE);

  always_comb begin
    case (req.op)
      ALU_OP_ADD_CARRY_ONLY: begin
        add_src = ALU_ZERO_WORD;
        add_cin = cur.status[ALU_SR_C];
      end
      ALU_OP_SUM_WITH_CARRY: begin
        add_src = req.src;
        add_cin = cur.status[ALU_SR_C];
      end
      default: begin
        add_src = req.src;
        add_cin = 1'b0;
      end
    endcase
  end

  // Carry out of width wrap
  alu_adder u_adder (
    .a(req.dst),
    .b(add_src),
    .carry_in(add_cin),
    .byte_sel(byte_mode),
    .res(add_res)
  );

  alu_logic_unit u_logic (
    .op(req.op),
    .src(req.src),
    .dst(req.dst),
    .byte_sel(byte_mode),
    .res(log_res)
  );

  // Mode bits only move when the status register is the destination
  function automatic logic [15:0] put_flags(input logic [15:0] sr,
                                            input alu_res_type r);
    logic [15:0] s;
    s = sr;
    s[ALU_SR_C] = r.c;
    s[ALU_SR_Z] = r.z;
    s[ALU_SR_N] = r.n;
    s[ALU_SR_V] = r.v;
    return s;
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.dst_we = 1'b0;
    next_cur.pc_we = 1'b0;
    next_cur.st = ALU_ST_IDLE;
    if (req_valid) begin
      next_cur.st = ALU_ST_DONE;
      case (req.op)
        ALU_OP_ADD, ALU_OP_SUM_WITH_CARRY, ALU_OP_ADD_CARRY_ONLY: begin
          next_cur.dst_we = 1'b1;
          next_cur.dst_data = add_res.value;
          next_cur.status = put_flags(cur.status, add_res);
        end
        ALU_OP_AND: begin
          next_cur.dst_we = 1'b1;
          next_cur.dst_data = log_res.value;
          next_cur.status = put_flags(cur.status, log_res);
        end
        ALU_OP_TEST: begin
          next_cur.status = put_flags(cur.status, log_res);
        end
        ALU_OP_CLEAR_MASKED_BITS, ALU_OP_SET_MASKED_BITS: begin
          next_cur.dst_we = 1'b1;
          next_cur.dst_data = log_res.value;
        end
        ALU_OP_JUMP_TO_TARGET: begin
          // Always a word move, whatever the select bit says
          next_cur.pc_we = 1'b1;
          next_cur.pc = req.dst;
        end
        default: begin
          next_cur.st = ALU_ST_IDLE;
        end
      endcase
      // Result lands in the status register; flag writes above discarded
      if (req.dst_is_sr && req.op != ALU_OP_TEST &&
          req.op != ALU_OP_JUMP_TO_TARGET) begin
        next_cur.status = next_cur.dst_data;
        next_cur.dst_we = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '{st: ALU_ST_IDLE, dst_we: 1'b0, dst_data: ALU_ZERO_WORD,
               pc_we: 1'b0, pc: ALU_PC_RESET, status: ALU_SR_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  assign dst_we = cur.dst_we;
  assign dst_data = cur.dst_data;
  assign pc_we = cur.pc_we;
  assign pc = cur.pc;
  assign status = cur.status;
  assign done = (cur.st == ALU_ST_DONE);

  logic plain_req;
  logic add_kind;
  logic logic_kind;
  assign plain_req = req_valid && !req.dst_is_sr;
  assign add_kind = req.op == ALU_OP_ADD ||
    req.op == ALU_OP_SUM_WITH_CARRY || req.op == ALU_OP_ADD_CARRY_ONLY;
  assign logic_kind = req.op == ALU_OP_AND || req.op == ALU_OP_TEST;

  // Request halves; every answer is checked one edge later
  sequence s_add_req;
    plain_req && req.op == ALU_OP_ADD;
  endsequence

  sequence s_any_add;
    plain_req && add_kind;
  endsequence

  sequence s_logic_flags;
    plain_req && logic_kind;
  endsequence

  sequence s_byte_write;
    plain_req && byte_mode && req.op != ALU_OP_TEST &&
      req.op != ALU_OP_JUMP_TO_TARGET;
  endsequence

  a_add_sum_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_add_req and !byte_mode) |=>
      dst_we && dst_data == $past(req.src) + $past(req.dst))
    else $error("add result wrong");

  a_add_carry_out: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_add_req and !byte_mode) |=> status[ALU_SR_C] ==
      ((17'($past(req.src)) + 17'($past(req.dst))) > 17'h0ffff))
    else $error("add carry wrong");

  a_carry_wrap: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_ADD_CARRY_ONLY && byte_mode |=>
      status[ALU_SR_C] == ($past(req.dst[7:0]) == 8'hff &&
      $past(cur.status[ALU_SR_C])))
    else $error("carry-only wrap wrong");

  a_carry_wrap_word: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_ADD_CARRY_ONLY && !byte_mode |=>
      status[ALU_SR_C] == ($past(req.dst) == ~ALU_ZERO_WORD &&
      $past(cur.status[ALU_SR_C])))
    else $error("carry-only word wrap wrong");

  a_carry_only_sum: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_ADD_CARRY_ONLY && !byte_mode |=>
      dst_we && dst_data ==
      $past(req.dst) + 16'($past(cur.status[ALU_SR_C])))
    else $error("carry-only sum wrong");

  a_sum_carry_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_SUM_WITH_CARRY && !byte_mode |=>
      dst_we && dst_data == $past(req.src) + $past(req.dst) +
      16'($past(cur.status[ALU_SR_C])))
    else $error("add-with-carry result wrong");

  a_sum_carry_out: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_SUM_WITH_CARRY && !byte_mode |=>
      status[ALU_SR_C] == ((17'($past(req.src)) + 17'($past(req.dst)) +
      17'($past(cur.status[ALU_SR_C]))) > 17'h0ffff))
    else $error("add-with-carry carry wrong");

  a_add_negative: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_any_add and !byte_mode) |=>
      status[ALU_SR_N] == dst_data[ALU_WORD_MSB])
    else $error("add negative flag wrong");

  // Signed overflow: like-signed operands, result of the other sign
  a_add_overflow: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_any_add and !byte_mode) |=> status[ALU_SR_V] ==
      ($past(req.dst[ALU_WORD_MSB]) == $past(add_src[ALU_WORD_MSB]) &&
      dst_data[ALU_WORD_MSB] != $past(req.dst[ALU_WORD_MSB])))
    else $error("add overflow flag wrong");

  a_add_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_any_add |=> status[ALU_SR_Z] == (dst_data == ALU_ZERO_WORD))
    else $error("add zero flag wrong");

  a_and_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_AND && !byte_mode |=>
      dst_we && dst_data == ($past(req.src) & $past(req.dst)))
    else $error("and result wrong");

  a_logic_negative: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_logic_flags and !byte_mode) |=> status[ALU_SR_N] ==
      ($past(req.src[ALU_WORD_MSB]) && $past(req.dst[ALU_WORD_MSB])))
    else $error("logic negative flag wrong");

  a_logic_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_logic_flags and !byte_mode) |=> status[ALU_SR_Z] ==
      (($past(req.src) & $past(req.dst)) == ALU_ZERO_WORD))
    else $error("logic zero flag wrong");

  a_and_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_logic_flags |=>
      status[ALU_SR_C] == !status[ALU_SR_Z] && !status[ALU_SR_V])
    else $error("logic carry or overflow wrong");

  a_test_no_write: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req_valid && req.op == ALU_OP_TEST |=> !dst_we && !pc_we)
    else $error("test wrote an operand");

  // Single-bit mask: carry reports the tested bit
  a_test_one_bit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_TEST && !byte_mode && $onehot(req.src)
      |=> status[ALU_SR_C] == |($past(req.src) & $past(req.dst)))
    else $error("bit test carry wrong");

  a_bits_keep_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && (req.op == ALU_OP_CLEAR_MASKED_BITS ||
    req.op == ALU_OP_SET_MASKED_BITS) |=> $stable(status))
    else $error("bit op changed flags");

  a_clear_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_CLEAR_MASKED_BITS && !byte_mode |=>
      dst_we && dst_data == (~$past(req.src) & $past(req.dst)))
    else $error("bit clear result wrong");

  a_set_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req && req.op == ALU_OP_SET_MASKED_BITS && !byte_mode |=>
      dst_we && dst_data == ($past(req.src) | $past(req.dst)))
    else $error("bit set result wrong");

  a_byte_upper_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_byte_write |=> dst_we && (dst_data & ~ALU_LOW_MASK) == ALU_ZERO_WORD)
    else $error("byte result spilled into upper byte");

  a_byte_add_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_add_req and byte_mode) |=> dst_data[ALU_BYTE_MSB:0] ==
      $past(req.src[ALU_BYTE_MSB:0]) + $past(req.dst[ALU_BYTE_MSB:0]))
    else $error("byte add result wrong");

  a_byte_add_carry: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_add_req and byte_mode) |=> status[ALU_SR_C] ==
      ((9'($past(req.src[ALU_BYTE_MSB:0])) +
      9'($past(req.dst[ALU_BYTE_MSB:0]))) > 9'h0ff))
    else $error("byte add carry wrong");

  a_byte_negative: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_any_add and byte_mode) |=>
      status[ALU_SR_N] == dst_data[ALU_BYTE_MSB])
    else $error("byte negative flag wrong");

  a_jump_load_pc: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req_valid && req.op == ALU_OP_JUMP_TO_TARGET |=>
      pc_we && pc == $past(req.dst) && $stable(status))
    else $error("jump target wrong");

  a_mode_bits_kept: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    plain_req |=> status[ALU_SR_OSC_HALT:ALU_SR_GIE] ==
      $past(cur.status[ALU_SR_OSC_HALT:ALU_SR_GIE]))
    else $error("mode bits changed");

  // Byte forms left out: the status register takes the masked value
  a_sr_dest_write: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req_valid && req.dst_is_sr && req.op == ALU_OP_AND && !byte_mode |=>
      status == ($past(req.src) & $past(req.dst)) && !dst_we)
    else $error("status destination wrong");

  a_sr_dest_bits: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req_valid && req.dst_is_sr && req.op == ALU_OP_SET_MASKED_BITS &&
      !byte_mode |=>
      status == ($past(req.src) | $past(req.dst)) && !dst_we)
    else $error("status destination set wrong");

endmodule

// *** test/alu_regfile_model.sv ***
`timescale 1ns/1ns
module alu_regfile_model
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dst_we,
  input wire logic [15:0] dst_data,
  input wire logic pc_we,
  input wire logic [15:0] pc,
  output logic [15:0] wb_reg,
  output logic [15:0] pc_reg
);
  // Holds only what was written back, so a missing or stray write shows
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wb_reg <= ALU_ZERO_WORD;
      pc_reg <= ALU_PC_RESET;
    end else begin
      if (dst_we)
        wb_reg <= dst_data;
      if (pc_we)
        pc_reg <= pc;
    end
  end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
  import alu_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  alu_req_type req = '0;
  logic dst_we, pc_we, done;
  logic [15:0] dst_data, pc, status, wb_reg, pc_reg;
  int fails = 0;
  int n_tests = 0;

  always #10 sys_clk = ~sys_clk;

  alu_core alu_core_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .dst_we(dst_we),
    .dst_data(dst_data), .pc_we(pc_we), .pc(pc), .status(status),
    .done(done));
  alu_regfile_model alu_regfile_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .dst_we(dst_we), .dst_data(dst_data), .pc_we(pc_we), .pc(pc),
    .wb_reg(wb_reg), .pc_reg(pc_reg));

  task automatic stop_test();
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One request, answer checked on the next edge, pulse end one later
  task automatic run(input alu_op_type o, input logic b, input logic s,
      input logic [15:0] sv, input logic [15:0] dv,
      input logic [15:0] ev, input logic ewe, input logic [15:0] est);
    logic [15:0] prev_wb;
    prev_wb = wb_reg;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req = '{op: o, byte_sel: b, dst_is_sr: s, src: sv, dst: dv};
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    `CHK(done, 1'b1)
    `CHK(dst_we, ewe)
    if (ewe)
      `CHK(dst_data, ev)
    `CHK(pc_we, o == ALU_OP_JUMP_TO_TARGET)
    `CHK(status, est)
    @(posedge sys_clk);
    #1;
    `CHK(done, 1'b0)
    if (!ewe)
      `CHK(wb_reg, prev_wb)
  endtask

  task automatic t_reset();
    `CHK(status, ALU_SR_RESET)
    `CHK(pc, ALU_PC_RESET)
    `CHK(dst_we, 1'b0)
  endtask

  task automatic t_add();
    run(ALU_OP_ADD, 0, 0, 16'h7fff, 16'h0001, 16'h8000, 1, 16'h0104);
    run(ALU_OP_ADD, 0, 0, 16'hffff, 16'h0001, 16'h0000, 1, 16'h0003);
    run(ALU_OP_ADD, 1, 0, 16'h00f6, 16'h120a, 16'h0000, 1, 16'h0003);
    run(ALU_OP_ADD, 1, 0, 16'h0040, 16'h0040, 16'h0080, 1, 16'h0104);
  endtask

  task automatic t_carry_only();
    run(ALU_OP_ADD, 0, 0, 16'hffff, 16'h0001, 16'h0000, 1, 16'h0003);
    run(ALU_OP_ADD_CARRY_ONLY, 1, 0, 0, 16'h33ff, 16'h0000, 1,
        16'h0003);
    run(ALU_OP_ADD_CARRY_ONLY, 0, 0, 0, 16'h7fff, 16'h8000, 1,
        16'h0104);
    run(ALU_OP_ADD_CARRY_ONLY, 0, 0, 0, 16'hffff, 16'hffff, 1,
        16'h0004);
  endtask

  task automatic t_sum_carry();
    run(ALU_OP_SUM_WITH_CARRY, 0, 0, 16'hffff, 16'h0001, 16'h0000, 1,
        16'h0003);
    run(ALU_OP_SUM_WITH_CARRY, 0, 0, 16'h0001, 16'h0002, 16'h0004, 1,
        16'h0000);
  endtask

  task automatic t_logic();
    run(ALU_OP_AND, 0, 0, 16'haa55, 16'h8001, 16'h8001, 1, 16'h0005);
    run(ALU_OP_AND, 1, 0, 16'h00a5, 16'hff5a, 16'h0000, 1, 16'h0002);
    run(ALU_OP_TEST, 0, 0, 16'h0200, 16'h0300, 0, 0, 16'h0001);
    run(ALU_OP_TEST, 1, 0, 16'h0008, 16'h0000, 0, 0, 16'h0002);
  endtask

  task automatic t_bits();
    run(ALU_OP_CLEAR_MASKED_BITS, 0, 0, 16'hfc00, 16'hffff, 16'h03ff, 1,
        16'h0002);
    run(ALU_OP_SET_MASKED_BITS, 1, 0, 16'h00e0, 16'h0001, 16'h00e1, 1,
        16'h0002);
    run(ALU_OP_SET_MASKED_BITS, 0, 0, 16'h003f, 16'h8000, 16'h803f, 1,
        16'h0002);
  endtask

  task automatic t_jump();
    run(ALU_OP_JUMP_TO_TARGET, 1, 0, 0, 16'hfffe, 0, 0, 16'h0002);
    `CHK(pc, 16'hfffe)
    `CHK(pc_reg, 16'hfffe)
  endtask

  // Mode bits set through the status destination must survive an add
  task automatic t_status_dest();
    run(ALU_OP_SET_MASKED_BITS, 0, 1, 16'h0038, 16'h0002, 0, 0,
        16'h003a);
    run(ALU_OP_ADD, 0, 0, 16'h0001, 16'hffff, 16'h0000, 1, 16'h003b);
    run(ALU_OP_CLEAR_MASKED_BITS, 0, 1, 16'h0039, 16'h003b, 0, 0,
        16'h0002);
    run(ALU_OP_AND, 0, 1, 16'h010f, 16'h013b, 0, 0, 16'h010b);
  endtask

  initial begin
    #40000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_add();
    t_carry_only();
    t_sum_carry();
    t_logic();
    t_bits();
    t_jump();
    t_status_dest();
    stop_test();
  end
endmodule
